// File: verilog/sgc_cfg.svh
// Constants of the switchgear control block: codes and default widths.
// Assumes inclusion by bare name from the package and testbench files.
`ifndef SGC_CFG_SVH
`define SGC_CFG_SVH
// ==========================================================
// Position codes
`define SGC_POS_INDET 2'h0
`define SGC_POS_OPEN 2'h1
`define SGC_POS_CLOSED 2'h2
`define SGC_POS_DISTURB 2'h3
// ==========================================================
// Switching authority codes
`define SGC_AUTH_NONE 2'h0
`define SGC_AUTH_LOCAL 2'h1
`define SGC_AUTH_REMOTE 2'h2
`define SGC_AUTH_BOTH 2'h3
// ==========================================================
// Default sizes
`define SGC_CNT_W 24
`define SGC_TRIP_N 8
`define SGC_ILOCK_N 3
`endif

// File: verilog/sgc_pkg.sv
// Types shared by the switchgear control modules.
// Assumes sgc_cfg.svh is on the include path.
`include "sgc_cfg.svh"
package sgc_pkg;
  // ==========================================================
  // Sequencer states and position code type
  typedef enum logic [2:0] {S_IDLE, S_SYNC, S_MOVE_C, S_MOVE_O, S_DWELL} sgc_state_t;
  typedef logic [1:0] sgc_pos_t;
endpackage

// File: verilog/sgc_trip_if.sv
// Bundle between the command sequencer and the trip manager.
// Assumes both ends share clk_i and rst_n_i.
`timescale 1ns/1ps
interface sgc_trip_if #(parameter int NT = 8, parameter int CW = 24);
  logic [NT-1:0] trip_in;
  logic [NT-1:0] trip_assign;
  logic [CW-1:0] hold_cycles;
  logic latch_en;
  logic ack;
  logic release_in;
  logic trip_cmd;
  modport mgr (input trip_in, trip_assign, hold_cycles, latch_en, ack, release_in,
    output trip_cmd);
  modport ctl (output trip_in, trip_assign, hold_cycles, latch_en, ack, release_in,
    input trip_cmd);
endinterface

// File: verilog/sgc_trip_mgr.sv
// Trip manager: ORs assigned protection trips, holds and latches the result.
// Assumes inputs synchronous to clk_i.
`timescale 1ns/1ps
module sgc_trip_mgr
  import sgc_pkg::*;
#(
  parameter int NT = `SGC_TRIP_N,
  parameter int CW = `SGC_CNT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Trip bundle
  sgc_trip_if.mgr tif
);
  // ==========================================================
  // Combining
  // Unassigned trips are masked, so they can never reach the breaker.
  wire logic any_trip = |(tif.trip_in & tif.trip_assign);
  wire logic none_assigned = ~|tif.trip_assign;
  wire logic latch_clr = ~any_trip &
    (tif.ack | tif.release_in | ~tif.latch_en | none_assigned);
  logic prev_r;
  logic latched_r;
  logic [CW-1:0] hold_r;
  wire logic trip_rise = any_trip & ~prev_r;

  // ==========================================================
  // Hold counter is loaded at the rising trip, so the minimum counts from the start.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_r <= 1'b0;
      hold_r <= '0;
    end else begin
      prev_r <= any_trip;
      if (trip_rise) begin
        hold_r <= tif.hold_cycles;
      end else if (hold_r != '0) begin
        hold_r <= hold_r - 1'b1;
      end
    end
  end

  // Setting wins over clearing; the clear itself demands all assigned trips dropped.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latched_r <= 1'b0;
    end else if (any_trip && tif.latch_en) begin
      latched_r <= 1'b1;
    end else if (latch_clr) begin
      latched_r <= 1'b0;
    end
  end

  assign tif.trip_cmd = any_trip | (hold_r != '0) | latched_r;

  // ==========================================================
  // Checks
  chk_hold_keeps_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hold_r != '0) |-> tif.trip_cmd) else $error("Trip dropped inside hold time.");
  chk_latch_stays: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    latched_r && !latch_clr |=> latched_r && tif.trip_cmd)
    else $error("Latched trip cleared without release.");
  chk_latch_needs_drop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    latched_r && any_trip |=> latched_r) else $error("Latch cleared with trip active.");
endmodule

// File: verilog/sgc_ctrl.sv
// Switchgear control top: single-contact position supervision, command
// sources, authority, interlocks, synchronism gate and trip manager.
// Assumes all inputs synchronous to clk_i; times arrive as clock counts.
//
// How it works
// - Close command starts move timer, shows indeterminate.
// - Close contact before expiry: closed, success.
// - Close move expiry unconfirmed gives disturbed.
// - Dwell after close move, then closed.
// - No contact assigned reports code three.
// - Open command timed; open contact gives success.
// - Open move expiry unconfirmed gives disturbed.
// - Dwell after open move, then open.
// - Three interlocks per direction block commands.
// - Protection open and reclose bypass interlocks.
// - Assigned protection trips are ORed together.
// - Only trip manager output trips the breaker.
// - Trip held minimum time, latch selectable.
// - Latched trip stays until acknowledged, released, latch disabled or no trip assigned.
// - Latch clears after trips drop plus release.
// - External close and open; open wins.
// - External close on edge, open on level.
// - Supervisory commands need remote authority.
// - Synchronism must come within supervision time.
// - Unassigned synchronism counts as always granted.
// - Authority none blocks switching, not trips or reclose.
// - Authority selects panel or remote sources.
// - Position code: 0 indet, 1 open, 2 closed, 3 disturbed.
// - Command pulse ends at move time or position.
`timescale 1ns/1ps
module sgc_ctrl
  import sgc_pkg::*;
#(
  parameter int CW = `SGC_CNT_W,
  parameter int NT = `SGC_TRIP_N,
  parameter int NI = `SGC_ILOCK_N
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Auxiliary contacts and their assignment
  input wire logic aux_close_i,
  input wire logic aux_open_i,
  input wire logic aux_close_wired_i,
  input wire logic aux_open_wired_i,
  // Timing configuration in clock cycles
  input wire logic [CW-1:0] move_close_cycles_i,
  input wire logic [CW-1:0] move_open_cycles_i,
  input wire logic [CW-1:0] dwell_cycles_i,
  input wire logic [CW-1:0] phase_match_timeout_i,
  input wire logic [CW-1:0] trip_hold_cycles_i,
  // Command sources
  input wire logic [1:0] authority_i,
  input wire logic panel_close_i,
  input wire logic panel_open_i,
  input wire logic scada_close_i,
  input wire logic scada_open_i,
  input wire logic internal_close_i,
  input wire logic internal_open_i,
  input wire logic external_close_input_i,
  input wire logic external_open_input_i,
  input wire logic auto_reclose_unit_close_i,
  // Interlocks and synchronism
  input wire logic [NI-1:0] close_ilock_i,
  input wire logic [NI-1:0] open_ilock_i,
  input wire logic prot_open_block_i,
  input wire logic phase_match_assigned_i,
  input wire logic phase_match_release_i,
  // Trip manager
  input wire logic [NT-1:0] prot_trip_i,
  input wire logic [NT-1:0] prot_trip_assign_i,
  input wire logic trip_latch_en_i,
  input wire logic trip_ack_i,
  input wire logic trip_release_input_i,
  // Breaker command relays
  output logic close_cmd_o,
  output logic open_cmd_o,
  output logic trip_cmd_o,
  // Position and result
  output sgc_pos_t pos_o,
  output logic pos_closed_o,
  output logic pos_open_o,
  output logic pos_indeterm_o,
  output logic pos_disturb_o,
  output logic command_success_o,
  output logic cmd_refused_o
);
  // ==========================================================
  // Parameter check
  if (CW < 2 || NT < 1 || NI < 1) begin : g_bad_param
    $error("sgc_ctrl: CW must be at least 2, NT and NI at least 1.");
  end

  // ==========================================================
  // Trip manager
  sgc_trip_if #(.NT(NT), .CW(CW)) tif ();
  assign tif.trip_in = prot_trip_i;
  assign tif.trip_assign = prot_trip_assign_i;
  assign tif.hold_cycles = trip_hold_cycles_i;
  assign tif.latch_en = trip_latch_en_i;
  assign tif.ack = trip_ack_i;
  assign tif.release_in = trip_release_input_i;

  sgc_trip_mgr #(.NT(NT), .CW(CW)) u_trip (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tif(tif)
  );

  // ==========================================================
  // State
  sgc_state_t st_r, st_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  sgc_pos_t idle_pos_r, idle_pos_nxt;
  logic dwell_close_r, dwell_close_nxt;
  logic succ_nxt, refuse_nxt;
  logic ext_close_q_r;
  logic aux_q_r;
  logic seen_r;

  // ==========================================================
  // Source selection
  // Authority never gates the trip path or the reclose unit.
  wire logic auth_local = (authority_i == `SGC_AUTH_LOCAL) ||
    (authority_i == `SGC_AUTH_BOTH);
  wire logic auth_remote = (authority_i == `SGC_AUTH_REMOTE) ||
    (authority_i == `SGC_AUTH_BOTH);
  wire logic ext_close_edge = external_close_input_i & ~ext_close_q_r;
  wire logic req_close = (panel_close_i & auth_local) |
    ((scada_close_i | internal_close_i | ext_close_edge) & auth_remote);
  wire logic req_open = (panel_open_i & auth_local) |
    ((scada_open_i | internal_open_i | external_open_input_i) & auth_remote);
  wire logic close_locked = |close_ilock_i;
  wire logic open_locked = |open_ilock_i;
  wire logic trip_eff = tif.trip_cmd & ~prot_open_block_i;
  wire logic do_open = (req_open & ~open_locked) | trip_eff;
  wire logic do_close = ((req_close & ~close_locked) | auto_reclose_unit_close_i) &
    ~do_open;
  wire logic sync_ok = ~phase_match_assigned_i | phase_match_release_i;

  // ==========================================================
  // Contact decoding
  // With both contacts assigned the close contact is the one supervised.
  wire logic close_mode = aux_close_wired_i;
  wire logic open_mode = aux_open_wired_i & ~aux_close_wired_i;
  wire logic unwired = ~aux_close_wired_i & ~aux_open_wired_i;
  wire logic aux_now = close_mode ? aux_close_i : aux_open_i;
  wire sgc_pos_t contact_pos = close_mode ?
    (aux_close_i ? `SGC_POS_CLOSED : `SGC_POS_OPEN) :
    (aux_open_i ? `SGC_POS_OPEN : `SGC_POS_CLOSED);
  wire logic conf_close = close_mode & aux_close_i;
  wire logic conf_open = open_mode & aux_open_i;
  wire logic expired = (cnt_r <= CW'(1));
  wire logic dwell_set = (dwell_cycles_i != '0);

  // ==========================================================
  // Sequencer
  // A new command is taken only from idle, a trip also from sync or close move, so commands never overlap.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
    idle_pos_nxt = idle_pos_r;
    dwell_close_nxt = dwell_close_r;
    succ_nxt = 1'b0;
    refuse_nxt = 1'b0;
    unique case (st_r)
      S_IDLE: begin
        if (!seen_r || aux_now != aux_q_r) begin
          idle_pos_nxt = contact_pos;
        end
        if (do_open) begin
          st_nxt = S_MOVE_O;
          cnt_nxt = move_open_cycles_i;
        end else if (do_close && !sync_ok) begin
          st_nxt = S_SYNC;
          cnt_nxt = phase_match_timeout_i;
        end else if (do_close) begin
          st_nxt = S_MOVE_C;
          cnt_nxt = move_close_cycles_i;
        end
      end
      S_SYNC: begin
        if (trip_eff) begin
          st_nxt = S_MOVE_O;
          cnt_nxt = move_open_cycles_i;
        end else if (sync_ok) begin
          st_nxt = S_MOVE_C;
          cnt_nxt = move_close_cycles_i;
        end else if (expired) begin
          st_nxt = S_IDLE;
          refuse_nxt = 1'b1;
        end
      end
      S_MOVE_C: begin
        if (trip_eff) begin
          st_nxt = S_MOVE_O;
          cnt_nxt = move_open_cycles_i;
        end else if (conf_close) begin
          st_nxt = S_IDLE;
          idle_pos_nxt = `SGC_POS_CLOSED;
          succ_nxt = 1'b1;
        end else if (expired && dwell_set) begin
          st_nxt = S_DWELL;
          cnt_nxt = dwell_cycles_i;
          dwell_close_nxt = 1'b1;
        end else if (expired) begin
          st_nxt = S_IDLE;
          idle_pos_nxt = close_mode ? `SGC_POS_DISTURB : contact_pos;
        end
      end
      S_MOVE_O: begin
        if (conf_open) begin
          st_nxt = S_IDLE;
          idle_pos_nxt = `SGC_POS_OPEN;
          succ_nxt = 1'b1;
        end else if (expired && dwell_set) begin
          st_nxt = S_DWELL;
          cnt_nxt = dwell_cycles_i;
          dwell_close_nxt = 1'b0;
        end else if (expired) begin
          st_nxt = S_IDLE;
          idle_pos_nxt = open_mode ? `SGC_POS_DISTURB : contact_pos;
        end
      end
      S_DWELL: begin
        if (expired) begin
          st_nxt = S_IDLE;
          idle_pos_nxt = dwell_close_r ? `SGC_POS_CLOSED : `SGC_POS_OPEN;
        end
      end
    endcase
  end

  // Shown position follows the next state so flags and state line up.
  wire logic moving_nxt = (st_nxt == S_MOVE_C) || (st_nxt == S_MOVE_O) ||
    (st_nxt == S_DWELL);
  wire sgc_pos_t pos_nxt = unwired ? `SGC_POS_DISTURB :
    (moving_nxt ? `SGC_POS_INDET : idle_pos_nxt);

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= S_IDLE;
      cnt_r <= '0;
      idle_pos_r <= `SGC_POS_INDET;
      dwell_close_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      idle_pos_r <= idle_pos_nxt;
      dwell_close_r <= dwell_close_nxt;
    end
  end

  // Edge history; the first idle cycle loads the position from the contact.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_close_q_r <= 1'b0;
      aux_q_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      ext_close_q_r <= external_close_input_i;
      aux_q_r <= aux_now;
      seen_r <= 1'b1;
    end
  end

  // ==========================================================
  // Output registers
  // The open relay also carries the trip so a blocked sequencer cannot hold it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      close_cmd_o <= 1'b0;
      open_cmd_o <= 1'b0;
      trip_cmd_o <= 1'b0;
      pos_o <= `SGC_POS_INDET;
      command_success_o <= 1'b0;
      cmd_refused_o <= 1'b0;
    end else begin
      close_cmd_o <= (st_nxt == S_MOVE_C);
      open_cmd_o <= (st_nxt == S_MOVE_O) | trip_eff;
      trip_cmd_o <= trip_eff;
      pos_o <= pos_nxt;
      command_success_o <= succ_nxt;
      cmd_refused_o <= refuse_nxt;
    end
  end

  assign pos_indeterm_o = (pos_o == `SGC_POS_INDET);
  assign pos_open_o = (pos_o == `SGC_POS_OPEN);
  assign pos_closed_o = (pos_o == `SGC_POS_CLOSED);
  assign pos_disturb_o = (pos_o == `SGC_POS_DISTURB);

  // ==========================================================
  // Checks
  sequence s_close_confirm;
    (st_r == S_MOVE_C) && !trip_eff && conf_close;
  endsequence
  sequence s_close_report;
    pos_closed_o && command_success_o ##1 !command_success_o;
  endsequence
  sequence s_open_confirm;
    (st_r == S_MOVE_O) && conf_open && !unwired;
  endsequence

  chk_close_success: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_close_confirm |=> s_close_report) else $error("Close confirm not reported.");
  chk_open_success: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_open_confirm |=> pos_open_o && command_success_o && !pos_indeterm_o)
    else $error("Open confirm not reported.");
  chk_move_indeterm: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_MOVE_C || st_r == S_DWELL) && !unwired |-> pos_o == `SGC_POS_INDET)
    else $error("Moving but not indeterminate.");
  chk_expiry_disturb: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_MOVE_C) && close_mode && expired && !dwell_set && !conf_close && !trip_eff
    |=> pos_disturb_o && !pos_indeterm_o) else $error("Expiry not disturbed.");
  chk_unwired_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    unwired |=> pos_o == 2'h3) else $error("Unassigned contact not disturbed.");
  chk_ilock_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_IDLE) && close_locked && !auto_reclose_unit_close_i
    |=> !close_cmd_o && st_r != S_SYNC) else $error("Interlocked close issued.");
  chk_open_priority: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_IDLE) && do_open && req_close |=> open_cmd_o && !close_cmd_o)
    else $error("Close beat open.");
  chk_auth_none: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_IDLE) && authority_i == `SGC_AUTH_NONE && !trip_eff &&
    !auto_reclose_unit_close_i |=> st_r == S_IDLE) else $error("Switched with no authority.");
  chk_sync_timeout: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st_r == S_SYNC) && expired && !sync_ok && !trip_eff
    |=> cmd_refused_o && !close_cmd_o ##1 !cmd_refused_o)
    else $error("Sync timeout did not refuse.");
  chk_pulse_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    close_cmd_o && (st_r == S_MOVE_C) && conf_close && !trip_eff |=> !close_cmd_o)
    else $error("Close pulse outlived position.");
endmodule

// File: testbench/sgc_breaker_model.sv
// Behavioural circuit breaker whose auxiliary contacts follow the relays.
// Assumes relay commands are registered levels synchronous to clk_i.
`timescale 1ns/1ps
module sgc_breaker_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Relay commands and behaviour control
  input wire logic close_cmd_i,
  input wire logic open_cmd_i,
  input wire logic stuck_i,
  input wire logic [3:0] delay_i,
  // Auxiliary contacts
  output logic aux_close_o,
  output logic aux_open_o
);
  // ==========================================================
  // Mechanism
  logic closed_r;
  logic [3:0] cnt_r;
  // A stuck mechanism never moves, so the block's move timer must run out.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      closed_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (!stuck_i && ((close_cmd_i && !closed_r) || (open_cmd_i && closed_r))) begin
      if (cnt_r >= delay_i) begin
        closed_r <= !closed_r;
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end else begin
      cnt_r <= 4'h0;
    end
  end
  // Both contacts are always driven; the block picks the one it listens to.
  assign aux_close_o = closed_r;
  assign aux_open_o = !closed_r;
endmodule

// File: testbench/test_sgc_ctrl.sv
// Self-checking bench for the switchgear control block with a breaker model.
// Assumes the design files and sgc_cfg.svh are compiled first.
`timescale 1ns/1ps
`include "sgc_cfg.svh"
module test_sgc_ctrl;
  import sgc_pkg::*;
  // ==========================================================
  // Stimulus and observation
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic aux_c, aux_o, pc, po, pi, pd, succ, refd, close_cmd_o, open_cmd_o, trip_cmd_o;
  logic wire_c = 1'b1, wire_o = 1'b0, stuck = 1'b0, blk = 1'b0, pm_as = 1'b0;
  logic pm_rel = 1'b0, latch = 1'b0, ack = 1'b0, rel = 1'b0, lt, li, ld, lc, lo;
  logic [3:0] dly = 4'h1;
  logic [23:0] dwell = 24'h000000;
  // Move times are variables so the timer inputs are not tied off at the instance.
  logic [23:0] mvc = 24'h000006, mvo = 24'h000006;
  logic [1:0] auth = 2'h1;
  logic [8:0] src = 9'h000;
  logic [2:0] ilc = 3'h0, ilo = 3'h0;
  logic [7:0] trip = 8'h00, tmask = 8'h0F;
  sgc_pos_t pos_o, lp;
  int err_count = 0, compares = 0, seed = 2827;
  int nc, no, nrc, nt, nind, nsuc, nref, prev;
  // Half period of the 40 MHz clock.
  always #12.5 clk_i = ~clk_i;
  // ==========================================================
  // Design and far side
  sgc_ctrl #(.CW(24), .NT(8), .NI(3)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .aux_close_i(aux_c), .aux_open_i(aux_o),
    .aux_close_wired_i(wire_c), .aux_open_wired_i(wire_o),
    .move_close_cycles_i(mvc), .move_open_cycles_i(mvo),
    .dwell_cycles_i(dwell), .phase_match_timeout_i(24'h000005),
    .trip_hold_cycles_i(24'h000005), .authority_i(auth),
    .panel_close_i(src[0]), .panel_open_i(src[1]), .scada_close_i(src[2]),
    .scada_open_i(src[3]), .internal_close_i(src[4]), .internal_open_i(src[5]),
    .external_close_input_i(src[6]), .external_open_input_i(src[7]),
    .auto_reclose_unit_close_i(src[8]), .close_ilock_i(ilc), .open_ilock_i(ilo),
    .prot_open_block_i(blk), .phase_match_assigned_i(pm_as),
    .phase_match_release_i(pm_rel), .prot_trip_i(trip), .prot_trip_assign_i(tmask),
    .trip_latch_en_i(latch), .trip_ack_i(ack), .trip_release_input_i(rel),
    .close_cmd_o(close_cmd_o), .open_cmd_o(open_cmd_o), .trip_cmd_o(trip_cmd_o),
    .pos_o(pos_o), .pos_closed_o(pc), .pos_open_o(po), .pos_indeterm_o(pi),
    .pos_disturb_o(pd), .command_success_o(succ), .cmd_refused_o(refd));
  sgc_breaker_model brk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .close_cmd_i(close_cmd_o),
    .open_cmd_i(open_cmd_o), .stuck_i(stuck), .delay_i(dly), .aux_close_o(aux_c),
    .aux_open_o(aux_o));
  // ==========================================================
  // Helpers
  // Every comparison goes through here so the counts stay honest.
  task automatic chk(input bit ok, input string msg);
    compares++;
    if (!ok) begin
      err_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  // Samples at falling edges, then returns on a rising edge so callers drive safely.
  task automatic watch(input int n);
    {nc, no, nrc, nt, nind, nsuc, nref, prev} = '0;
    repeat (n) begin
      @(negedge clk_i);
      if (close_cmd_o === 1'b1 && prev == 0) nrc++;
      prev = (close_cmd_o === 1'b1);
      nc += (close_cmd_o === 1'b1);
      no += (open_cmd_o === 1'b1);
      nt += (trip_cmd_o === 1'b1);
      nind += (pi === 1'b1);
      nsuc += (succ === 1'b1);
      nref += (refd === 1'b1);
      lp = pos_o;
      lt = trip_cmd_o;
      ld = pd;
      li = pi;
      lc = pc;
      lo = po;
    end
    @(posedge clk_i);
  endtask
  // One-cycle source pulse with a fresh random breaker delay.
  task automatic go(input int k, input int n);
    @(posedge clk_i);
    src[k] <= 1'b1;
    dly <= 4'h1 + 4'($random(seed) & 32'h1);
    @(posedge clk_i);
    src[k] <= 1'b0;
    watch(n);
  endtask
  task automatic hit(input int b, input int n);
    @(posedge clk_i);
    trip[b] <= 1'b1;
    @(posedge clk_i);
    trip[b] <= 1'b0;
    watch(n);
  endtask
  task automatic tend(input string s);
    $display("Test %s finished, mismatches %0d", s, err_count);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The whole run needs under a thousand cycles; this is a generous margin.
  initial begin
    #(25 * 20000);
    err_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done;
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    watch(2);
    chk(lp === `SGC_POS_OPEN && lo === 1'b1, "open after reset");
    go(0, 12);
    chk(nrc == 1 && nc <= 6 && nind > 0, "close pulse");
    chk(lp === `SGC_POS_CLOSED && nsuc == 1 && li === 1'b0 && lc === 1'b1,
      "close confirmed");
    go(1, 12);
    stuck <= 1'b1;
    go(0, 12);
    chk(nc == 6 && lp === `SGC_POS_DISTURB && ld === 1'b1, "close expired");
    dwell <= 24'h000004;
    go(0, 20);
    chk(nind > 8 && lp === `SGC_POS_CLOSED, "close dwell");
    stuck <= 1'b0;
    dwell <= 24'h000000;
    go(1, 12);
    tend("close contact");
    wire_c <= 1'b0;
    wire_o <= 1'b1;
    go(0, 12);
    go(1, 12);
    chk(nsuc == 1 && no <= 6 && nind > 0 && lp === `SGC_POS_OPEN && lo === 1'b1,
      "open ok");
    go(0, 12);
    stuck <= 1'b1;
    go(1, 12);
    chk(no == 6 && lp === `SGC_POS_DISTURB && nsuc == 0, "open expired");
    dwell <= 24'h000004;
    go(1, 20);
    chk(nind > 8 && lp === `SGC_POS_OPEN, "open dwell");
    stuck <= 1'b0;
    dwell <= 24'h000000;
    go(1, 12);
    wire_o <= 1'b0;
    watch(3);
    chk(lp === `SGC_POS_DISTURB && ld === 1'b1, "no contact assigned");
    wire_c <= 1'b1;
    go(0, 12);
    go(1, 12);
    tend("open contact");
    for (int i = 0; i < 3; i++) begin
      ilc <= 3'(1 << i);
      go(0, 8);
      chk(nc == 0, "close interlocked");
    end
    go(8, 12);
    chk(nc > 0 && lp === `SGC_POS_CLOSED, "reclose bypass");
    for (int i = 0; i < 3; i++) begin
      ilo <= 3'(1 << i);
      go(1, 8);
      chk(no == 0, "open interlocked");
    end
    ilo <= 3'h7;
    auth <= 2'h0;
    hit($random(seed) & 3, 12);
    chk(no > 0 && nt >= 5 && nt <= 6, "trip held and bypasses");
    {ilc, ilo} <= 6'h00;
    hit(7, 8);
    chk(nt == 0 && no == 0, "unassigned trip");
    blk <= 1'b1;
    hit(0, 8);
    chk(nt == 0, "trip blocked");
    blk <= 1'b0;
    latch <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      trip[0] <= 1'b1;
      watch(3);
      {ack, rel} <= (j == 0) ? 2'h2 : 2'h1;
      watch(1);
      {ack, rel, trip[0]} <= 3'h0;
      watch(12);
      chk(lt === 1'b1, "latched after drop");
      {ack, rel} <= (j == 0) ? 2'h2 : 2'h1;
      watch(1);
      {ack, rel} <= 2'h0;
      watch(4);
      chk(lt === 1'b0, "latch released");
    end
    hit(0, 10);
    latch <= 1'b0;
    // Long enough for the last trip-driven open move to end before the next edge request.
    watch(10);
    chk(lt === 1'b0, "latch disabled");
    tend("trip");
    auth <= 2'h2;
    src[6] <= 1'b1;
    watch(24);
    chk(nrc == 1 && lp === `SGC_POS_CLOSED, "close on edge");
    src[7:6] <= 2'h2;
    // A held open level restarts the move, so more than one pulse length is seen;
    // fourteen cycles also put the next close edge on an idle cycle.
    watch(14);
    chk(no > 6 && aux_c === 1'b0, "open on level");
    src[6] <= 1'b1;
    watch(12);
    chk(nc == 0, "open wins");
    src[7:6] <= 2'h0;
    watch(8);
    for (int a = 0; a < 4; a++) begin
      for (int k = 0; k < 6; k += 2) begin
        auth <= 2'(a);
        go(k, 12);
        chk((nc > 0) == (((k == 0) ? a : a >> 1) & 1), "authority gate");
        auth <= 2'h3;
        go(1, 12);
      end
    end
    pm_as <= 1'b1;
    go(0, 14);
    chk(nc == 0 && nref == 1, "sync timeout");
    fork
      go(0, 14);
      begin
        repeat (3) @(posedge clk_i);
        pm_rel <= 1'b1;
      end
    join
    chk(nc > 0, "sync granted");
    go(1, 12);
    {pm_as, pm_rel} <= 2'h0;
    go(0, 12);
    chk(nc > 0, "sync unassigned");
    tend("sources");
    test_done;
  end
endmodule
